//--- hw/utt_consts.vh
`ifndef UTT_CONSTS_VH
`define UTT_CONSTS_VH

// Register bus geometry.
`define UTT_ADDR_W            12
`define UTT_DATA_W            32

// Register byte addresses.
`define UTT_ADDR_TUNING       12'h06c
`define UTT_ADDR_STATUS       12'h070

// Tuning register fields and reset values.
`define UTT_BIT_WMD           0
`define UTT_BIT_RBD           1
`define UTT_RBD_RST           1'h0
`define UTT_WMD_RST           1'h0

// Status register fields.
`define UTT_ST_WM_EN          0
`define UTT_ST_RB_EN          1
`define UTT_ST_STRAP          2
`define UTT_ST_LOADED         3
`define UTT_ST_THR_LSB        16
`define UTT_ST_THR_MSB        26

// Bus answer constants.
`define UTT_ZERO_WORD         32'h0000_0000

// Strap settling after reset release, in clock cycles.
`define UTT_STRAP_SETTLE      2'h2
`define UTT_STRAP_DONE        2'h3
`define UTT_CNT_RST           2'h0
`define UTT_CNT_ONE           2'h1

// Packet sizes and OUT watermark levels, in bytes.
`define UTT_SIZE_W            11
`define UTT_SIZE_ZERO         11'h000
`define UTT_WM_L0             11'h0bf
`define UTT_WM_L1             11'h0ff
`define UTT_WM_L2             11'h17f
`define UTT_WM_L3             11'h1ff
`define UTT_WM_L4             11'h27f
`define UTT_WM_L5             11'h2ff

`endif

//--- hw/utt_sync2.v
`timescale 1ns/100ps

// Two-stage synchroniser; the first stage feeds only the second.
module utt_sync2 (
  clk,
  rst_n,
  d,
  q
);
  input  wire clk;
  input  wire rst_n;
  input  wire d;
  output wire q;

  reg meta_reg;
  reg sync_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

//--- hw/utt_tuning.v
// Functional notes
// - Tuning register sits at byte offset 0x6C, 32 bits, read and write.
// - Ring buffer disable bit resets to the strap pin level.
// - Watermark disable bit resets to the strap pin level.
// - Writing 1 disables ring buffering; 0 enables it if strap is low.
// - Writing 1 disables OUT watermark; 0 enables it if strap is low.
// - Strap high makes the ring buffer disable bit read 1.
// - Strap high makes the watermark disable bit read 1.
// - Ring buffering enabled only with strap low and disable bit low.
// - Watermark enabled only with strap low and disable bit low.
// - Ring buffering lets the next IN packet start right after one ends.
// - Watermark starts OUT once fetched bytes reach the chosen level.
`timescale 1ns/100ps
`include "utt_consts.vh"

module utt_tuning (
  ref_clk,
  rst_n,
  clk_en,
  tuning_strap_pin,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  in_packet_done,
  in_drain_done,
  in_start_permit,
  out_packet_active,
  out_max_size,
  out_fetched,
  out_start,
  out_threshold,
  ring_buffer_enable,
  out_watermark_enable
);
  input  wire                     ref_clk;
  input  wire                     rst_n;
  input  wire                     clk_en;
  input  wire                     tuning_strap_pin;
  input  wire                     psel;
  input  wire                     penable;
  input  wire                     pwrite;
  input  wire [`UTT_ADDR_W-1:0]   paddr;
  input  wire [`UTT_DATA_W-1:0]   pwdata;
  output reg  [`UTT_DATA_W-1:0]   prdata;
  output reg                      pready;
  output reg                      pslverr;
  input  wire                     in_packet_done;
  input  wire                     in_drain_done;
  output reg                      in_start_permit;
  input  wire                     out_packet_active;
  input  wire [`UTT_SIZE_W-1:0]   out_max_size;
  input  wire [`UTT_SIZE_W-1:0]   out_fetched;
  output reg                      out_start;
  output reg  [`UTT_SIZE_W-1:0]   out_threshold;
  output reg                      ring_buffer_enable;
  output reg                      out_watermark_enable;

  // Largest listed watermark below the packet size; a packet too small
  // for any level falls back to its own full size.
  function [`UTT_SIZE_W-1:0] wm_level;
    input [`UTT_SIZE_W-1:0] max_size;
    begin
      if (max_size > `UTT_WM_L5) begin
        wm_level = `UTT_WM_L5;
      end else if (max_size > `UTT_WM_L4) begin
        wm_level = `UTT_WM_L4;
      end else if (max_size > `UTT_WM_L3) begin
        wm_level = `UTT_WM_L3;
      end else if (max_size > `UTT_WM_L2) begin
        wm_level = `UTT_WM_L2;
      end else if (max_size > `UTT_WM_L1) begin
        wm_level = `UTT_WM_L1;
      end else if (max_size > `UTT_WM_L0) begin
        wm_level = `UTT_WM_L0;
      end else begin
        wm_level = max_size;
      end
    end
  endfunction

  // Byte count at which an OUT packet may go out on the bus.
  function [`UTT_SIZE_W-1:0] start_level;
    input                   wm_en;
    input [`UTT_SIZE_W-1:0] max_size;
    begin
      if (wm_en) begin
        start_level = wm_level(max_size);
      end else begin
        start_level = max_size;
      end
    end
  endfunction

  // A disable bit reads as set while the strap forces the feature off.
  function bit_seen;
    input stored;
    input strap;
    begin
      bit_seen = stored | strap;
    end
  endfunction

  // A feature runs only with the strap low and its disable bit clear, and
  // stays off until the strap has been loaded after reset.
  function feature_on;
    input loaded;
    input strap;
    input dis;
    begin
      feature_on = loaded && !strap && !dis;
    end
  endfunction

  // Full-word compare of the bus address against one register address.
  function addr_hit;
    input [`UTT_ADDR_W-1:0] addr;
    input [`UTT_ADDR_W-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Unmapped addresses and writes to the read-only status word are refused.
  function bus_refused;
    input is_tuning;
    input is_status;
    input is_write;
    begin
      bus_refused = !(is_tuning || (is_status && !is_write));
    end
  endfunction

  // Read image of the tuning word; the upper bits are not stored.
  function [`UTT_DATA_W-1:0] tuning_word;
    input rbd_bit;
    input wmd_bit;
    begin
      tuning_word = `UTT_ZERO_WORD;
      tuning_word[`UTT_BIT_RBD] = rbd_bit;
      tuning_word[`UTT_BIT_WMD] = wmd_bit;
    end
  endfunction

  // Read image of the status word.
  function [`UTT_DATA_W-1:0] status_word;
    input                   wm_en;
    input                   rb_en;
    input                   strap;
    input                   loaded;
    input [`UTT_SIZE_W-1:0] thr;
    begin
      status_word = `UTT_ZERO_WORD;
      status_word[`UTT_ST_WM_EN]  = wm_en;
      status_word[`UTT_ST_RB_EN]  = rb_en;
      status_word[`UTT_ST_STRAP]  = strap;
      status_word[`UTT_ST_LOADED] = loaded;
      status_word[`UTT_ST_THR_MSB:`UTT_ST_THR_LSB] = thr;
    end
  endfunction

  // Busy is set by a received IN packet and cleared by its drain; a new
  // packet in the same cycle as a drain keeps it set.
  function next_busy;
    input busy;
    input done;
    input drain;
    begin
      if (done) begin
        next_busy = 1'b1;
      end else if (drain) begin
        next_busy = 1'b0;
      end else begin
        next_busy = busy;
      end
    end
  endfunction

  wire                    rst_sync_n;
  wire                    strap_sync;

  reg  [1:0]              load_cnt_reg;
  reg  [1:0]              load_cnt_next;
  reg                     rbd_reg;
  reg                     rbd_next;
  reg                     wmd_reg;
  reg                     wmd_next;
  reg                     in_busy_reg;
  reg                     in_busy_next;
  reg                     out_started_reg;
  reg                     out_started_next;

  reg                     rbd_read;
  reg                     wmd_read;
  reg                     rb_en_now;
  reg                     wm_en_now;
  reg  [`UTT_SIZE_W-1:0]  thr_now;
  reg                     hit_tuning;
  reg                     hit_status;
  reg                     setup_phase;
  reg                     access_done;
  reg  [`UTT_DATA_W-1:0]  read_word;
  reg                     strap_ready;
  reg                     write_tuning;

  utt_sync2 u_rst_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (1'b1),
    .q     (rst_sync_n)
  );

  utt_sync2 u_strap_sync (
    .clk   (ref_clk),
    .rst_n (rst_sync_n),
    .d     (tuning_strap_pin),
    .q     (strap_sync)
  );

  // Decode, effective enables and read data.
  always @* begin
    hit_tuning   = addr_hit(paddr, `UTT_ADDR_TUNING);
    hit_status   = addr_hit(paddr, `UTT_ADDR_STATUS);
    setup_phase  = psel && !penable;
    access_done  = psel && penable && pready;
    write_tuning = access_done && pwrite && hit_tuning;
    strap_ready  = (load_cnt_reg == `UTT_STRAP_DONE);
    rbd_read     = bit_seen(rbd_reg, strap_sync);
    wmd_read     = bit_seen(wmd_reg, strap_sync);
    rb_en_now    = feature_on(strap_ready, strap_sync, rbd_reg);
    wm_en_now    = feature_on(strap_ready, strap_sync, wmd_reg);
    thr_now      = start_level(wm_en_now, out_max_size);
    read_word    = `UTT_ZERO_WORD;
    if (hit_tuning) begin
      read_word = tuning_word(rbd_read, wmd_read);
    end else if (hit_status) begin
      read_word = status_word(wm_en_now, rb_en_now, strap_sync,
                              strap_ready, thr_now);
    end
  end

  // Strap load counter: counts up once after reset and then rests.
  always @* begin
    load_cnt_next = load_cnt_reg;
    if (load_cnt_reg != `UTT_STRAP_DONE) begin
      load_cnt_next = load_cnt_reg + `UTT_CNT_ONE;
    end
  end

  // Next state of the tuning bits.
  always @* begin
    rbd_next = rbd_reg;
    wmd_next = wmd_reg;
    // The strap is sampled once its synchroniser has filled.
    if (load_cnt_reg == `UTT_STRAP_SETTLE) begin
      rbd_next = strap_sync;
      wmd_next = strap_sync;
    end
    // A software write in the load cycle wins over the strap default.
    if (write_tuning) begin
      rbd_next = pwdata[`UTT_BIT_RBD];
      wmd_next = pwdata[`UTT_BIT_WMD];
    end
  end

  // IN overlap tracking.
  always @* begin
    in_busy_next = next_busy(in_busy_reg, in_packet_done, in_drain_done);
  end

  // OUT start tracking, rearmed when the packet ends.
  always @* begin
    out_started_next = out_started_reg;
    if (!out_packet_active) begin
      out_started_next = 1'b0;
    end else if (out_fetched >= thr_now) begin
      out_started_next = 1'b1;
    end
  end

  // Stored tuning bits and the strap load counter.
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      load_cnt_reg <= `UTT_CNT_RST;
      rbd_reg      <= `UTT_RBD_RST;
      wmd_reg      <= `UTT_WMD_RST;
    end else if (clk_en) begin
      load_cnt_reg <= load_cnt_next;
      rbd_reg      <= rbd_next;
      wmd_reg      <= wmd_next;
    end
  end

  // Bus answer: every setup cycle gets a one-cycle access phase.
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata  <= `UTT_ZERO_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (setup_phase) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? `UTT_ZERO_WORD : read_word;
        pslverr <= bus_refused(hit_tuning, hit_status, pwrite);
      end else begin
        pready  <= 1'b0;
        prdata  <= `UTT_ZERO_WORD;
        pslverr <= 1'b0;
      end
    end
  end

  // Transfer engine tracking state.
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      in_busy_reg     <= 1'b0;
      out_started_reg <= 1'b0;
    end else if (clk_en) begin
      in_busy_reg     <= in_busy_next;
      out_started_reg <= out_started_next;
    end
  end

  // Qualifiers handed to the transfer engines.
  always @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ring_buffer_enable   <= 1'b0;
      out_watermark_enable <= 1'b0;
      in_start_permit      <= 1'b0;
      out_start            <= 1'b0;
      out_threshold        <= `UTT_SIZE_ZERO;
    end else if (clk_en) begin
      ring_buffer_enable   <= rb_en_now;
      out_watermark_enable <= wm_en_now;
      // Without ring buffering the next IN waits for the drain.
      in_start_permit      <= rb_en_now || !in_busy_next;
      out_start            <= out_started_next && !out_started_reg;
      out_threshold        <= thr_now;
    end
  end

endmodule

//--- test/utt_tuning_props.sv
`timescale 1ns/100ps
module utt_tuning_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        tuning_strap_pin,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        in_packet_done,
  input wire logic        in_drain_done,
  input wire logic        in_start_permit,
  input wire logic        out_start,
  input wire logic        ring_buffer_enable,
  input wire logic        out_watermark_enable
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  answer_one_a: assert property (
    psel && !penable && clk_en |=> pready) else $error("no answer");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("pready too long");
  unmapped_err_a: assert property (
    pready && paddr != 12'h06c && paddr != 12'h070
    |-> pslverr && prdata == 32'h0000_0000) else $error("bad unmapped");
  strap_read_a: assert property (
    tuning_strap_pin [*4] ##0 (pready && !pwrite && paddr == 12'h06c)
    |-> prdata[1:0] == 2'h3) else $error("strap read");
  strap_off_a: assert property (
    (tuning_strap_pin && clk_en) [*4]
    |-> !ring_buffer_enable && !out_watermark_enable) else $error("strap");
  start_pulse_a: assert property (
    out_start |=> !out_start) else $error("out_start too long");
  ring_permit_a: assert property (
    (ring_buffer_enable && clk_en) [*2] |-> in_start_permit)
    else $error("no permit");
  busy_hold_a: assert property (
    !ring_buffer_enable && clk_en && in_packet_done && !in_drain_done ##1
    !ring_buffer_enable && clk_en && !in_drain_done |=> !in_start_permit)
    else $error("permit while busy");
endmodule

//--- test/utt_tuning_tb.sv
`timescale 1ns/100ps
module utt_tuning_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n, clk_en, tuning_strap_pin, psel, penable, pwrite, er;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, in_packet_done, in_drain_done;
  logic        in_start_permit, out_packet_active, out_start;
  logic [10:0] out_max_size, out_fetched, out_threshold, cap;
  logic        ring_buffer_enable, out_watermark_enable;
  logic [1:0]  dis;
  integer      bad_count = 0, checked = 0, cyc = 0, seed = 68, i, k, cnt;

  utt_tuning i_utt_tuning (.ref_clk, .rst_n, .clk_en, .tuning_strap_pin,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_packet_done, .in_drain_done, .in_start_permit, .out_packet_active,
    .out_max_size, .out_fetched, .out_start, .out_threshold,
    .ring_buffer_enable, .out_watermark_enable);

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      results;
    end
  end

  task automatic results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked = checked + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One idle cycle before each setup keeps every drive in its own step.
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [1:0] d);
    apb(1'b1, 12'h06c, {30'h0, d});
    dis = d;
  endtask

  task automatic vfy;
    logic [1:0] eff;
    logic [1:0] en;
    eff = dis | {2{tuning_strap_pin}};
    en = ~eff;
    apb(1'b0, 12'h06c, 32'h0000_0000);
    chk(rd, {30'h0, eff});
    chk(er, 1'b0);
    apb(1'b0, 12'h070, 32'h0000_0000);
    chk(rd[3:0], {1'b1, tuning_strap_pin, en});
    chk({ring_buffer_enable, out_watermark_enable}, en);
  endtask

  function automatic logic [10:0] thr_of(input logic [10:0] mx,
                                         input logic wm);
    logic [10:0] lv [6] = '{11'h0bf, 11'h0ff, 11'h17f, 11'h1ff, 11'h27f,
                            11'h2ff};
    thr_of = mx;
    for (int j = 0; j < 6; j++)
      if (wm && lv[j] < mx)
        thr_of = lv[j];
  endfunction

  task automatic inp(input logic mid);
    in_packet_done <= 1'b1;
    @(posedge ref_clk);
    in_packet_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(in_start_permit, mid);
    in_drain_done <= 1'b1;
    @(posedge ref_clk);
    in_drain_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(in_start_permit, 1'b1);
  endtask

  task automatic outp(input logic [10:0] mx, input logic wm);
    logic [10:0] t;
    t = thr_of(mx, wm);
    out_max_size <= mx;
    out_fetched <= 11'h000;
    out_packet_active <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(out_threshold, t);
    cnt = 0;
    for (k = 1; k <= mx + 2; k++) begin
      @(posedge ref_clk);
      if (out_start === 1'b1) begin
        cnt = cnt + 1;
        cap = out_fetched;
      end
      out_fetched <= (k < mx) ? k[10:0] : mx;
    end
    chk(cnt, 1);
    chk(cap, (t < mx) ? t + 11'h001 : mx);
    out_packet_active <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    tuning_strap_pin = 1'b1;
    {psel, penable, pwrite, in_packet_done, in_drain_done} = 5'h00;
    {out_packet_active, paddr, pwdata} = 45'h0;
    {out_max_size, out_fetched} = 22'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    dis = 2'h3;
    repeat (6) @(posedge ref_clk);
    vfy;
    tuning_strap_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    vfy;
    for (i = 0; i < 8; i++) begin
      tuning_strap_pin <= i[2];
      wr(i[1:0]);
      repeat (4) @(posedge ref_clk);
      vfy;
    end
    a = {4'h1, 6'($random(seed)), 2'h0};
    apb(1'b1, a, 32'hffff_ffff);
    chk(er, 1'b1);
    apb(1'b0, a, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h070, 32'h0000_0000);
    chk(er, 1'b1);
    vfy;
    tuning_strap_pin <= 1'b0;
    wr(2'h2);
    repeat (4) @(posedge ref_clk);
    inp(1'b0);
    outp(11'h400, 1'b1);
    outp(11'h0c0, 1'b1);
    outp(11'h0bf, 1'b1);
    for (i = 0; i < 3; i++)
      outp(11'({$random(seed)} % 925 + 100), 1'b1);
    wr(2'h1);
    repeat (4) @(posedge ref_clk);
    inp(1'b1);
    outp(11'h400, 1'b0);
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    dis = 2'h0;
    repeat (6) @(posedge ref_clk);
    vfy;
    clk_en <= 1'b0;
    tuning_strap_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({ring_buffer_enable, out_watermark_enable}, 32'h0000_0003);
    clk_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    vfy;
    results;
  end
endmodule

bind utt_tuning utt_tuning_props i_utt_tuning_props (.ref_clk, .rst_n,
  .clk_en, .tuning_strap_pin, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .in_packet_done, .in_drain_done, .in_start_permit,
  .out_start, .ring_buffer_enable, .out_watermark_enable);
